// *** bench/alman_panel.sv ***
// operator front panel model driving the two acknowledge buttons
`timescale 1ns/1ps
module alman_panel #(
   parameter int HOLD = 6
) (
   input wire logic clock,
   input wire logic press,
   output logic ack_button_a,
   output logic ack_button_b
);
   int cnt = 0;
   // ================
   // both buttons go down on one edge, so the press is never seen as a lone button
   always @(posedge clock) begin
      if (press && cnt == 0) cnt <= HOLD;
      else if (cnt != 0) cnt <= cnt - 1;
   end
   assign ack_button_a = cnt != 0;
   assign ack_button_b = cnt != 0;
endmodule

// *** bench/alman_top_sva.sv ***
// port checker for the alarm annunciator
`timescale 1ns/1ps
module alman_top_sva #(
   parameter int TICK_CYC = alman_pkg::ALMAN_TICK_CYC
) (
   // clock, reset and inputs
   input wire logic clock,
   input wire logic rst,
   input wire logic out_saturated,
   input wire logic err_reducing,
   input wire logic autotune_done,
   input wire logic [alman_pkg::ALMAN_NUM-1:0] alm_configured,
   input wire logic [alman_pkg::ALMAN_NUM-1:0] alm_soft,
   input wire logic [alman_pkg::ALMAN_NUM-1:0] relay_map [alman_pkg::ALMAN_RELAYS],
   input wire logic [alman_pkg::ALMAN_TW-1:0] integral_time,
   // outputs
   input wire alman_pkg::alman_ind_t alm_ind [alman_pkg::ALMAN_NUM],
   input wire logic [alman_pkg::ALMAN_RELAYS-1:0] relay,
   input wire logic loop_break_alarm,
   input wire logic [alman_pkg::ALMAN_TW-1:0] loop_break_period
);
   import alman_pkg::*;
   // ================
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   property p_unconf; !alm_configured[3] |-> alm_ind[3] == ALMAN_IND_OFF; endproperty
   a_unconf: assert property (p_unconf) else $error("unconfigured alarm shows");
   property p_new; $past(alm_ind[0]) == ALMAN_IND_OFF && alm_ind[0] != ALMAN_IND_OFF |-> alm_ind[0] == ALMAN_IND_DOUBLE; endproperty
   a_new: assert property (p_new) else $error("new alarm not double flash");
   property p_single; alm_ind[0] == ALMAN_IND_SINGLE |-> $past(alm_ind[0]) != ALMAN_IND_OFF; endproperty
   a_single: assert property (p_single) else $error("single flash without alarm");
   property p_nodbl; $past(alm_ind[0]) == ALMAN_IND_SINGLE |-> alm_ind[0] != ALMAN_IND_DOUBLE; endproperty
   a_nodbl: assert property (p_nodbl) else $error("acked alarm back to double");
   property p_hold; relay_map[0] == 4'h1 && !alm_soft[0] && alm_ind[0] != ALMAN_IND_OFF |-> relay[0]; endproperty
   a_hold: assert property (p_hold) else $error("relay dropped while alarm shown");
   property p_lbr; $rose(loop_break_alarm) |-> $past(out_saturated, 2) && !$past(err_reducing, 2); endproperty
   a_lbr: assert property (p_lbr) else $error("loop break without saturation");
   property p_tune; autotune_done [*4] |=> loop_break_period == integral_time * 24'h3; endproperty
   a_tune: assert property (p_tune) else $error("period not three integral times");
   property p_rst; $fell(rst) |-> relay == 4'h0 && !loop_break_alarm && alm_ind[0] == ALMAN_IND_OFF; endproperty
   a_rst: assert property (p_rst) else $error("outputs active after reset");
   c_single: cover property (alm_ind[0] == ALMAN_IND_SINGLE);
   c_lbr: cover property ($rose(loop_break_alarm));
   c_or: cover property (relay == 4'h9);
endmodule
bind alman_top alman_top_sva #(.TICK_CYC(TICK_CYC)) i_sva (.clock, .rst, .out_saturated, .err_reducing,
   .autotune_done, .alm_configured, .alm_soft, .relay_map, .integral_time, .alm_ind, .relay, .loop_break_alarm,
   .loop_break_period);

// *** bench/alman_top_tb.sv ***
// self-checking testbench for the alarm annunciator
`timescale 1ns/1ps
module alman_top_tb;
   import alman_pkg::*;
   logic clock = 0, rst = 1, clk_en = 1, press = 0, ack_button_a, ack_button_b, loop_break_alarm;
   logic out_saturated = 0, err_reducing = 0, autotune_done = 0, loop_break_enable = 1;
   logic signed [ALMAN_VW-1:0] pv_level [ALMAN_NUM] = '{default: 0};
   logic signed [ALMAN_VW-1:0] alm_trip [ALMAN_NUM] = '{default: 16'sh64};
   logic [ALMAN_VW-1:0] alm_hyst [ALMAN_NUM] = '{default: 16'ha};
   logic [ALMAN_TW-1:0] alm_delay [ALMAN_NUM] = '{24'h3, 24'h0, 24'h0, 24'h0};
   logic [ALMAN_NUM-1:0] relay_map [ALMAN_RELAYS] = '{4'h1, 4'h2, 4'h4, 4'h9};
   logic [ALMAN_NUM-1:0] alm_configured = 4'h7, alm_high = 4'hf, alm_blocking = 4'h0, alm_soft = 4'h2, alm_event = 4'h4;
   logic [ALMAN_TW-1:0] loop_break_manual = 24'h2, integral_time = 24'h5, loop_break_period;
   logic [ALMAN_RELAYS-1:0] relay;
   alman_ind_t alm_ind [ALMAN_NUM];
   int n_errors = 0, check_count = 0;
   alman_top #(.TICK_CYC(4)) i_dut (.clock, .rst, .clk_en, .pv_level, .ack_button_a, .ack_button_b, .out_saturated,
      .err_reducing, .autotune_done, .alm_configured, .alm_high, .alm_blocking, .alm_soft, .alm_event, .alm_trip,
      .alm_hyst, .alm_delay, .relay_map, .loop_break_manual, .integral_time, .loop_break_enable, .alm_ind, .relay,
      .loop_break_alarm, .loop_break_period);
   alman_panel i_panel (.clock, .press, .ack_button_a, .ack_button_b);
   always #4 clock = ~clock;
   // ================
   task automatic cyc(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // alarm 3 stays low so the unconfigured slot never sees a condition
   task automatic set_pv(input logic signed [ALMAN_VW-1:0] v);
      for (int i = 0; i < 3; i++) pv_level[i] = v;
   endtask
   task automatic ack();
      press = 1;
      cyc(1);
      press = 0;
      cyc(15);
   endtask
   task automatic conclude();
      $display("checks %0d errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   initial begin
      #20000;
      n_errors++;
      conclude();
   end
   initial begin
      cyc(5);
      rst = 0;
      set_pv(16'sh96);
      cyc(10);
      chk(alm_ind[0], ALMAN_IND_OFF);
      chk(alm_ind[1], ALMAN_IND_DOUBLE);
      chk(alm_ind[2], ALMAN_IND_OFF);
      cyc(15);
      chk(alm_ind[0], ALMAN_IND_DOUBLE);
      chk(alm_ind[3], ALMAN_IND_OFF);
      chk(relay, 4'hd);
      set_pv(16'sh5f);
      cyc(10);
      chk(alm_ind[0], ALMAN_IND_DOUBLE);
      ack();
      chk(alm_ind[0], ALMAN_IND_SINGLE);
      chk(relay, 4'hd);
      set_pv(16'sh50);
      cyc(10);
      chk(alm_ind[0], ALMAN_IND_OFF);
      chk(relay, 4'h0);
      set_pv(16'sh96);
      cyc(25);
      set_pv(16'sh50);
      cyc(10);
      chk(alm_ind[0], ALMAN_IND_DOUBLE);
      chk(relay, 4'h9);
      ack();
      chk(alm_ind[0], ALMAN_IND_OFF);
      chk(relay, 4'h0);
      out_saturated = 1;
      cyc(20);
      chk(loop_break_alarm, 1'b1);
      chk(loop_break_period, 24'h2);
      err_reducing = 1;
      cyc(6);
      chk(loop_break_alarm, 1'b0);
      autotune_done = 1;
      cyc(8);
      chk(loop_break_period, 24'hf);
      conclude();
   end
endmodule

// *** core/alman_top.sv ***
// per-alarm annunciation, loop-break supervision and relay mapping
`timescale 1ns/1ps
module alman_top #(
   parameter int TICK_CYC = alman_pkg::ALMAN_TICK_CYC
) (
   // clock and reset
   input wire logic clock,
   input wire logic rst,
   input wire logic clk_en,
   // process inputs (asynchronous)
   input wire logic signed [alman_pkg::ALMAN_VW-1:0] pv_level [alman_pkg::ALMAN_NUM],
   input wire logic ack_button_a,
   input wire logic ack_button_b,
   input wire logic out_saturated,
   input wire logic err_reducing,
   input wire logic autotune_done,
   // configuration
   input wire logic [alman_pkg::ALMAN_NUM-1:0] alm_configured,
   input wire logic [alman_pkg::ALMAN_NUM-1:0] alm_high,
   input wire logic [alman_pkg::ALMAN_NUM-1:0] alm_blocking,
   input wire logic [alman_pkg::ALMAN_NUM-1:0] alm_soft,
   input wire logic [alman_pkg::ALMAN_NUM-1:0] alm_event,
   input wire logic signed [alman_pkg::ALMAN_VW-1:0] alm_trip [alman_pkg::ALMAN_NUM],
   input wire logic [alman_pkg::ALMAN_VW-1:0] alm_hyst [alman_pkg::ALMAN_NUM],
   input wire logic [alman_pkg::ALMAN_TW-1:0] alm_delay [alman_pkg::ALMAN_NUM],
   input wire logic [alman_pkg::ALMAN_NUM-1:0] relay_map [alman_pkg::ALMAN_RELAYS],
   input wire logic [alman_pkg::ALMAN_TW-1:0] loop_break_manual,
   input wire logic [alman_pkg::ALMAN_TW-1:0] integral_time,
   input wire logic loop_break_enable,
   // indication and outputs
   output alman_pkg::alman_ind_t alm_ind [alman_pkg::ALMAN_NUM],
   output logic [alman_pkg::ALMAN_RELAYS-1:0] relay,
   output logic loop_break_alarm,
   output logic [alman_pkg::ALMAN_TW-1:0] loop_break_period
);
   import alman_pkg::*;

   // ==========================================================
   // state
   typedef struct packed {
      logic [ALMAN_NUM*ALMAN_VW-1:0] pv_s1;
      logic [ALMAN_NUM*ALMAN_VW-1:0] pv_s2;
      logic [4:0] in_s1;
      logic [4:0] in_s2;
      logic ack_prev;
      logic [31:0] tick_cnt;
      logic [ALMAN_NUM-1:0] cond;
      logic [ALMAN_NUM-1:0] armed;
      logic [ALMAN_NUM*ALMAN_TW-1:0] dly_cnt;
      logic [ALMAN_NUM-1:0] present;
      logic [ALMAN_NUM*2-1:0] st;
      logic [ALMAN_NUM*2-1:0] ind;
      logic [ALMAN_RELAYS-1:0] relay;
      logic [ALMAN_TW-1:0] lb_period;
      logic [ALMAN_TW-1:0] lb_cnt;
      logic lb_alarm;
   } alman_state_t;

   alman_state_t cur;
   alman_state_t next_cur;

   logic tick;
   logic ack_now;
   logic [ALMAN_NUM-1:0] latched;

   always_comb begin
      logic signed [ALMAN_VW:0] lvl;
      logic signed [ALMAN_VW:0] trip;
      logic signed [ALMAN_VW:0] rel;
      logic [ALMAN_TW-1:0] dcnt;
      alman_st_t s;
      lvl = '0;
      trip = '0;
      rel = '0;
      dcnt = '0;
      s = ALMAN_ST_IDLE;
      next_cur = cur;
      latched = '0;
      // ========================================================
      // input synchronisers
      for (int i = 0; i < ALMAN_NUM; i++) begin
         next_cur.pv_s1[i*ALMAN_VW +: ALMAN_VW] = pv_level[i];
      end
      next_cur.pv_s2 = cur.pv_s1;
      next_cur.in_s1 = {autotune_done, err_reducing, out_saturated, ack_button_b, ack_button_a};
      next_cur.in_s2 = cur.in_s1;
      // combined press of both buttons, taken on its rising edge
      ack_now = cur.in_s2[0] && cur.in_s2[1] && !cur.ack_prev;
      next_cur.ack_prev = cur.in_s2[0] && cur.in_s2[1];
      tick = (cur.tick_cnt == 32'(TICK_CYC - 1));
      next_cur.tick_cnt = tick ? 32'h0 : cur.tick_cnt + 32'h1;
      // ========================================================
      // per-alarm detection and annunciation
      for (int i = 0; i < ALMAN_NUM; i++) begin
         lvl = {cur.pv_s2[i*ALMAN_VW + ALMAN_VW-1], cur.pv_s2[i*ALMAN_VW +: ALMAN_VW]};
         trip = {alm_trip[i][ALMAN_VW-1], alm_trip[i]};
         // release point sits a hysteresis band inside the trip point
         if (alm_high[i]) begin
            rel = trip - $signed({1'b0, alm_hyst[i]});
            if (lvl > trip) begin
               next_cur.cond[i] = 1'b1;
            end else if (lvl <= rel) begin
               next_cur.cond[i] = 1'b0;
            end
         end else begin
            rel = trip + $signed({1'b0, alm_hyst[i]});
            if (lvl < trip) begin
               next_cur.cond[i] = 1'b1;
            end else if (lvl >= rel) begin
               next_cur.cond[i] = 1'b0;
            end
         end
         // blocking: arm only once the condition has been seen safe
         if (!alm_blocking[i] || !cur.cond[i]) next_cur.armed[i] = 1'b1;
         // delay counted in ticks while condition and arming hold
         dcnt = cur.dly_cnt[i*ALMAN_TW +: ALMAN_TW];
         if (!(cur.cond[i] && cur.armed[i])) begin
            dcnt = '0;
            next_cur.present[i] = 1'b0;
         end else if (dcnt >= alm_delay[i]) begin
            next_cur.present[i] = 1'b1;
         end else if (tick) begin
            dcnt = dcnt + 1'b1;
         end
         next_cur.dly_cnt[i*ALMAN_TW +: ALMAN_TW] = dcnt;
         if (!alm_configured[i]) next_cur.present[i] = 1'b0;
         // annunciation state machine
         s = alman_st_t'(cur.st[i*2 +: 2]);
         case (s)
            ALMAN_ST_IDLE: begin
               if (cur.present[i]) begin
                  s = ALMAN_ST_ACTIVE;
               end
            end
            ALMAN_ST_ACTIVE: begin
               if (ack_now && cur.present[i]) begin
                  s = ALMAN_ST_ACKED;
               end else if (ack_now) begin
                  s = ALMAN_ST_IDLE;
               end else if (!cur.present[i]) begin
                  // condition gone before ack: keep flashing and hold the relay
                  s = ALMAN_ST_LATCH;
               end
            end
            ALMAN_ST_ACKED: begin
               if (!cur.present[i]) begin
                  s = ALMAN_ST_IDLE;
               end
            end
            ALMAN_ST_LATCH: begin
               if (ack_now) begin
                  s = ALMAN_ST_IDLE;
               end else if (cur.present[i]) begin
                  s = ALMAN_ST_ACTIVE;
               end
            end
            default: begin
               s = ALMAN_ST_IDLE;
            end
         endcase
         // events need no acknowledge: they follow the condition
         if (alm_event[i]) begin
            s = cur.present[i] ? ALMAN_ST_ACKED : ALMAN_ST_IDLE;
         end
         if (!alm_configured[i]) begin
            s = ALMAN_ST_IDLE;
         end
         next_cur.st[i*2 +: 2] = s;
         latched[i] = (s != ALMAN_ST_IDLE);
         // indication: double until acked, single while acked and present
         if (alm_event[i] || s == ALMAN_ST_IDLE) begin
            next_cur.ind[i*2 +: 2] = ALMAN_IND_OFF;
         end else if (s == ALMAN_ST_ACKED) begin
            next_cur.ind[i*2 +: 2] = ALMAN_IND_SINGLE;
         end else begin
            next_cur.ind[i*2 +: 2] = ALMAN_IND_DOUBLE;
         end
         // soft alarms never reach a relay
         if (alm_soft[i]) begin
            latched[i] = 1'b0;
         end
      end
      // ========================================================
      // relay mapping: OR of selected alarms, held by annunciator state
      for (int r = 0; r < ALMAN_RELAYS; r++) begin
         next_cur.relay[r] = |(relay_map[r] & latched);
      end
      // ========================================================
      // loop-break supervisor
      if (cur.in_s2[4]) begin
         next_cur.lb_period = ALMAN_TW'(integral_time * ALMAN_LB_MULT);
      end else if (cur.lb_period == '0) begin
         // manual period only fills an empty period, so a tuned value survives
         next_cur.lb_period = loop_break_manual;
      end
      if (!loop_break_enable || !cur.in_s2[2] || cur.in_s2[3]) begin
         next_cur.lb_cnt = '0;
         next_cur.lb_alarm = 1'b0;
      end else if (cur.lb_cnt >= cur.lb_period) begin
         next_cur.lb_alarm = 1'b1;
      end else if (tick) begin
         next_cur.lb_cnt = cur.lb_cnt + 1'b1;
      end
   end

   // reset wins over the clock enable; a low enable freezes every register
   always_ff @(posedge clock) begin
      if (rst) begin
         cur <= '0;
      end else if (clk_en) begin
         cur <= next_cur;
      end
   end

   always_comb begin
      for (int i = 0; i < ALMAN_NUM; i++) begin
         alm_ind[i] = alman_ind_t'(cur.ind[i*2 +: 2]);
      end
   end
   assign relay = cur.relay;
   assign loop_break_alarm = cur.lb_alarm;
   assign loop_break_period = cur.lb_period;
endmodule

// *** pkg/alman_pkg.sv ***
// constants and types for the alarm annunciator
package alman_pkg;
   localparam int ALMAN_NUM = 4;
   localparam int ALMAN_VW = 16;
   localparam int ALMAN_TW = 24;
   localparam int ALMAN_RELAYS = 4;
   localparam int ALMAN_CLK_MHZ = 125;
   // one timing tick is 1 ms
   localparam int ALMAN_TICK_US = 1000;
   localparam int ALMAN_TICK_CYC = ALMAN_TICK_US * ALMAN_CLK_MHZ;
   localparam logic [2:0] ALMAN_LB_MULT = 3'h3;

   // indication code per alarm
   typedef enum logic [1:0] {
      ALMAN_IND_OFF = 2'h0,
      ALMAN_IND_DOUBLE = 2'h1,
      ALMAN_IND_SINGLE = 2'h3
   } alman_ind_t;

   // per-alarm state, gray along idle->active->acked->latch
   typedef enum logic [1:0] {
      ALMAN_ST_IDLE = 2'h0,
      ALMAN_ST_ACTIVE = 2'h1,
      ALMAN_ST_ACKED = 2'h3,
      ALMAN_ST_LATCH = 2'h2
   } alman_st_t;
endpackage
